// >>> acct_fifo.sv
// Purpose: result buffer between the filter and the serial output
// Assumes: single clock, clock enable freezes everything
// Notes:   full and empty come from a count, so depth need not be 2^n
`timescale 1ns/1ns
module acct_fifo #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic             clk_en_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // handshakes, honest against the count
    assign wr_ready_out = (count_ff != CW'(DEPTH));
    assign rd_valid_out = (count_ff != '0);
    assign push         = clk_en_in & wr_valid_in & wr_ready_out;
    assign pop          = clk_en_in & rd_ready_in & rd_valid_out;
    assign rd_data_out  = mem_ff[rd_ptr_ff];

    // storage has no reset, only the pointers matter
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= wr_data_in;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            if (pop) rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            if (push & ~pop) count_ff <= count_ff + 1'b1;
            else if (pop & ~push) count_ff <= count_ff - 1'b1;
        end
    end
endmodule

// >>> acct_host.sv
// Purpose: behavioural host that masters the serial port
// Assumes: serial clock half period of 8 clk_in cycles, idle low
// Notes:   a released data pin reads as a toggling level, never a hold
`timescale 1ns/1ns
module acct_host (
    input  wire logic clk_in,
    input  wire logic sdo_in,
    input  wire logic oe_in,
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      din_out
);
    logic pin_level;
    logic last_ff;
    // undriven pin shows the inverse of its last value, so no stale bit
    assign pin_level = oe_in ? sdo_in : ~last_ff;
    always_ff @(posedge clk_in) begin
        last_ff <= pin_level;
    end
    // serial clock stands still low outside frames
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out  = 1'b0;
    end
    // n bits msb first; chip select is left low for the caller
    task automatic xfer(input logic [31:0] tx, input int n,
                        output logic [31:0] rx, output logic drove);
        rx    = '0;
        drove = 1'b1;
        @(posedge clk_in) cs_n_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            sclk_out <= 1'b1;
            din_out  <= tx[31-i];
            repeat (7) @(posedge clk_in);
            @(negedge clk_in);
            rx    = {rx[30:0], pin_level};
            drove = drove & oe_in;
            @(posedge clk_in) sclk_out <= 1'b0;
            // low half is 8 clocks with the next rise, 160 ns period
            repeat (7) @(posedge clk_in);
        end
    endtask
    // raising chip select abandons any partial frame
    task automatic close();
        repeat (8) @(posedge clk_in);
        cs_n_out <= 1'b1;
        @(posedge clk_in);
    endtask
endmodule

// >>> acct_pkg.sv
// Purpose: shared constants, pin bundle and state type for the
//          converter timing control block
// Assumes: converter clock is the block clock, one period per cycle
// Notes:   all cycle figures count converter clock periods
package acct_pkg;
    localparam int unsigned RESULT_W            = 24;
    localparam int unsigned FIFO_DEPTH          = 8;
    localparam int unsigned SCLK_IDLE_CYC       = 65540;
    localparam int unsigned RST_LOW_MIN_CYC     = 4;
    localparam int unsigned START_LEVEL_MIN_CYC = 4;
    localparam int unsigned STOP_SETUP_CYC      = 100;
    localparam int unsigned STOP_HOLD_CYC       = 150;
    localparam int unsigned RESULT_READY_N_HIGH_MIN_CYC   = 16;
    localparam int unsigned RESET_TO_CONV_CYC   = 512;
    localparam int unsigned POR_TO_COMM_CYC     = 65536;
    localparam int unsigned COMM_TO_CONV_CYC    = 512;
    localparam int unsigned ACX_BLANK_CYC       = 8;
    localparam int unsigned ACX_PERIOD_CONV     = 2;
    localparam int unsigned START_TO_RESULT_READY_N_CYC   = 2;
    localparam int unsigned CONV_PERIOD_CYC     = 3072;
    localparam real         OSC_SLOW_MHZ        = 7.3728;
    localparam real         OSC_FAST_MHZ        = 10.24;
    // serial command byte
    localparam int unsigned CMD_W               = 8;
    localparam logic [7:0]  CMD_RESET           = 8'h06;
    localparam logic [7:0]  CMD_START           = 8'h08;
    localparam logic [7:0]  CMD_STOP            = 8'h0A;

    // pins arriving from outside the clock domain
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
        logic start;
        logic rst_n;
        logic power_down_n_n;
    } acct_pins_s;

    localparam acct_pins_s PINS_RST = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    typedef enum logic [2:0] {
        ST_POWERUP = 3'h0,
        ST_SETTLE  = 3'h1,
        ST_IDLE    = 3'h3,
        ST_CONVERT = 3'h2,
        ST_LAST    = 3'h6
    } acct_state_e;
endpackage

// >>> acct_top.sv
// Purpose: conversion sequencing, serial port and excitation timing
// Assumes: clk_in is the converter clock; pins are asynchronous
// Notes:   shared data pin is split into value and enable
`timescale 1ns/1ns
module acct_top
    import acct_pkg::*;
#(
    parameter int unsigned DATA_W     = RESULT_W,
    parameter int unsigned DEPTH      = FIFO_DEPTH,
    parameter int unsigned IDLE_CYC   = SCLK_IDLE_CYC,
    parameter int unsigned POR_CYC    = POR_TO_COMM_CYC,
    parameter int unsigned CONV_CYC   = CONV_PERIOD_CYC
) (
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    input  wire logic              clk_en_in,
    input  wire logic              reset_pin_n_in,
    input  wire logic              start_in,
    input  wire logic              power_down_n_in,
    input  wire logic              cs_n_in,
    input  wire logic              sclk_in,
    input  wire logic              din_in,
    input  wire logic [DATA_W-1:0] sample_data_in,
    input  wire logic              sample_valid_in,
    output logic                   sample_ready_out,
    input  wire logic              ac_enable_in,
    input  wire logic              rate_fast_in,
    output logic                   osc_fast_out,
    output logic                   result_ready_n_out,
    output logic                   shared_serial_out_ready_n_out,
    output logic                   shared_serial_out_ready_n_oe_out,
    output logic             [1:0] ac_excitation_drive_out,
    output logic                   comm_ready_out,
    output logic                   converting_out
);
    acct_pins_s    pins;
    acct_pins_s    s1_ff, s2_ff, s3_ff, flt_ff, chg;
    acct_state_e   state_ff;
    logic [16:0]   por_cnt_ff, idle_cnt_ff;
    logic [9:0]    settle_cnt_ff;
    logic [15:0]   conv_cnt_ff;
    logic [7:0]    since_fall_ff, hi_cnt_ff;
    logic [2:0]    rst_low_ff;
    logic [3:0]    blank_ff;
    logic [4:0]    bit_cnt_ff;
    logic [7:0]    cmd_sr_ff;
    logic [DATA_W-1:0] dout_sr_ff, result_ff, fifo_data;
    logic          shifting_ff, out_bit_ff, result_ready_n_n_ff, run_ff;
    logic          phase_ff, fifo_valid, comm_ok, settle_done;
    logic          sclk_rise, sclk_fall, cs_rise, cs_fall, spi_active;
    logic          spi_timeout, cmd_fire, cmd_reset, pin_reset;
    logic          start_req, stop_req, conv_done, conv_start;
    logic          early_stop, result_ready_n_up, in_conv;
    logic [7:0]    cmd_word;

    function automatic logic [7:0] sat_inc8(input logic [7:0] v);
        sat_inc8 = (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    assign pins = '{cs_n_in, sclk_in, din_in, start_in,
                    reset_pin_n_in, power_down_n_in};

    // three-stage sampling; a change counts once stages two and three agree
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s1_ff  <= PINS_RST;
            s2_ff  <= PINS_RST;
            s3_ff  <= PINS_RST;
            flt_ff <= PINS_RST;
        end else if (clk_en_in) begin
            s1_ff  <= pins;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            flt_ff <= flt_ff ^ chg;
        end
    end

    // edge decode, only from stages two and three
    assign chg        = ~(s2_ff ^ s3_ff) & (s2_ff ^ flt_ff);
    assign sclk_rise  = chg.sclk & s2_ff.sclk;
    assign sclk_fall  = chg.sclk & ~s2_ff.sclk;
    assign cs_rise    = chg.cs_n & s2_ff.cs_n;
    assign cs_fall    = chg.cs_n & ~s2_ff.cs_n;
    assign comm_ok    = (por_cnt_ff == 17'(POR_CYC));
    assign spi_active = ~flt_ff.cs_n & comm_ok;
    assign spi_timeout = spi_active & (idle_cnt_ff == 17'(IDLE_CYC - 1));

    // command byte decode on the eighth falling edge
    assign cmd_word  = {cmd_sr_ff[6:0], flt_ff.din};
    assign cmd_fire  = sclk_fall & spi_active & (bit_cnt_ff == 5'd7);
    assign cmd_reset = cmd_fire & (cmd_word == CMD_RESET);
    assign pin_reset = ~flt_ff.rst_n & (rst_low_ff == 3'(RST_LOW_MIN_CYC));
    // pin level and commands are interchangeable
    assign start_req = (chg.start & s2_ff.start)
                     | (cmd_fire & (cmd_word == CMD_START));
    assign stop_req  = (chg.start & ~s2_ff.start)
                     | (cmd_fire & (cmd_word == CMD_STOP))
                     | ~flt_ff.power_down_n_n;
    assign in_conv     = (state_ff == ST_CONVERT) | (state_ff == ST_LAST);
    assign conv_done   = in_conv & (conv_cnt_ff == 16'(CONV_CYC - 1));
    assign result_ready_n_up     = in_conv
                       & (conv_cnt_ff == 16'(CONV_CYC - 1 - RESULT_READY_N_HIGH_MIN_CYC));
    assign early_stop  = since_fall_ff < 8'(STOP_SETUP_CYC);
    assign settle_done = (settle_cnt_ff == 10'(RESET_TO_CONV_CYC - 1));
    assign conv_start  = ((state_ff == ST_IDLE) & run_ff & ~stop_req)
                       | (conv_done & (state_ff == ST_CONVERT) & ~stop_req)
                       | (in_conv & start_req);

    // power-on wait, reset pin low count, idle timer
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            por_cnt_ff  <= '0;
            rst_low_ff  <= '0;
            idle_cnt_ff <= '0;
        end else if (clk_en_in) begin
            if (!comm_ok) por_cnt_ff <= por_cnt_ff + 17'd1;
            if (flt_ff.rst_n) rst_low_ff <= '0;
            else if (!pin_reset) rst_low_ff <= rst_low_ff + 3'd1;
            if (chg.sclk | cs_rise | ~spi_active | spi_timeout) begin
                idle_cnt_ff <= '0;
            end else begin
                idle_cnt_ff <= idle_cnt_ff + 17'd1;
            end
        end
    end

    // serial shifter; inputs on falling edges, outputs on rising edges
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            bit_cnt_ff  <= '0;
            cmd_sr_ff   <= '0;
            dout_sr_ff  <= '0;
            shifting_ff <= 1'b0;
            out_bit_ff  <= 1'b0;
        end else if (clk_en_in) begin
            if (!spi_active | spi_timeout | cs_fall) begin
                bit_cnt_ff  <= '0;
                shifting_ff <= 1'b0;
                dout_sr_ff  <= result_ff;
            end else if (sclk_rise & (bit_cnt_ff < 5'(DATA_W))) begin
                shifting_ff <= 1'b1;
                out_bit_ff  <= dout_sr_ff[DATA_W-1];
                dout_sr_ff  <= {dout_sr_ff[DATA_W-2:0], 1'b0};
            end else if (sclk_fall) begin
                cmd_sr_ff <= cmd_word;
                if (bit_cnt_ff != 5'h1F) bit_cnt_ff <= bit_cnt_ff + 5'd1;
                if (bit_cnt_ff == 5'(DATA_W - 1)) shifting_ff <= 1'b0;
            end
        end
    end

    // shared pin: data while shifting, ready otherwise
    assign shared_serial_out_ready_n_out =
        shifting_ff ? out_bit_ff : result_ready_n_n_ff;
    assign shared_serial_out_ready_n_oe_out = spi_active;

    // sequencing state; early stop aborts, late stop runs one more
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff      <= ST_POWERUP;
            settle_cnt_ff <= '0;
            conv_cnt_ff   <= '0;
            run_ff        <= 1'b0;
        end else if (clk_en_in) begin
            if (start_req) run_ff <= 1'b1;
            else if (stop_req) run_ff <= 1'b0;
            if (pin_reset | cmd_reset) begin
                state_ff      <= ST_SETTLE;
                settle_cnt_ff <= '0;
                run_ff        <= 1'b0;
            end else begin
                settle_cnt_ff <= settle_cnt_ff + 10'd1;
                conv_cnt_ff   <= conv_start ? '0 : conv_cnt_ff + 16'd1;
                case (state_ff)
                    ST_POWERUP: begin
                        settle_cnt_ff <= '0;
                        if (comm_ok) state_ff <= ST_SETTLE;
                    end
                    ST_SETTLE: begin
                        if (settle_done) begin
                            state_ff <= ST_IDLE;
                            run_ff   <= flt_ff.start;
                        end
                    end
                    ST_IDLE: begin
                        if (conv_start) state_ff <= ST_CONVERT;
                    end
                    ST_CONVERT: begin
                        if (stop_req & ~start_req) begin
                            state_ff <= early_stop ? ST_IDLE
                                                   : ST_LAST;
                        end else if (conv_done & ~conv_start) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                    ST_LAST: begin
                        if (start_req) state_ff <= ST_CONVERT;
                        else if (conv_done) state_ff <= ST_IDLE;
                    end
                    default: state_ff <= ST_POWERUP;
                endcase
            end
        end
    end

    // ready output, result capture and time since ready fell
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            result_ready_n_n_ff     <= 1'b1;
            result_ff     <= '0;
            since_fall_ff <= 8'hFF;
            hi_cnt_ff     <= 8'hFF;
        end else if (clk_en_in) begin
            hi_cnt_ff     <= result_ready_n_n_ff ? sat_inc8(hi_cnt_ff) : '0;
            since_fall_ff <= sat_inc8(since_fall_ff);
            if (conv_done & ~start_req & fifo_valid) begin
                result_ff     <= fifo_data;
                result_ready_n_n_ff     <= 1'b0;
                since_fall_ff <= '0;
            end else if (start_req | result_ready_n_up | pin_reset | cmd_reset) begin
                result_ready_n_n_ff <= 1'b1;
            end
        end
    end

    // excitation: toggle per conversion, blank both drives meanwhile
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            phase_ff <= 1'b0;
            blank_ff <= '0;
        end else if (clk_en_in) begin
            if (conv_start & ac_enable_in) begin
                phase_ff <= ~phase_ff;
                blank_ff <= 4'(ACX_BLANK_CYC);
            end else if (blank_ff != '0) begin
                blank_ff <= blank_ff - 4'd1;
            end
        end
    end

    assign ac_excitation_drive_out =
        (!ac_enable_in || blank_ff != '0) ? 2'h0 :
        (phase_ff ? 2'h2 : 2'h1);
    assign result_ready_n_out = result_ready_n_n_ff;
    assign comm_ready_out     = comm_ok;
    assign converting_out     = in_conv;
    assign osc_fast_out       = rate_fast_in; // selects fast oscillator

    // filter results wait here until a conversion period closes
    acct_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .reset_in     (reset_in),
        .clk_en_in    (clk_en_in),
        .wr_data_in   (sample_data_in),
        .wr_valid_in  (sample_valid_in),
        .wr_ready_out (sample_ready_out),
        .rd_data_out  (fifo_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (conv_done & ~start_req)
    );

    property p_idle_reset;
        @(posedge clk_in) disable iff (reset_in)
        (clk_en_in && spi_timeout) |=> (bit_cnt_ff == 0 && !shifting_ff);
    endproperty
    a_idle_reset: assert property (p_idle_reset)
        else $error("idle timeout did not clear serial port");

    property p_cs_idle;
        @(posedge clk_in) disable iff (reset_in)
        (clk_en_in && cs_rise) |=> ##1 (!shifting_ff && bit_cnt_ff == 0);
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("chip select high left serial port busy");

    property p_early_stop;
        @(posedge clk_in) disable iff (reset_in)
        (clk_en_in && state_ff == ST_CONVERT && stop_req && !start_req
         && !pin_reset && !cmd_reset && since_fall_ff < 100)
        |=> state_ff == ST_IDLE;
    endproperty
    a_early_stop: assert property (p_early_stop)
        else $error("early stop did not cancel next conversion");

    property p_late_stop;
        @(posedge clk_in) disable iff (reset_in)
        (clk_en_in && state_ff == ST_CONVERT && stop_req && !start_req
         && !pin_reset && !cmd_reset && since_fall_ff >= 150)
        |=> state_ff == ST_LAST;
    endproperty
    a_late_stop: assert property (p_late_stop)
        else $error("late stop did not finish next conversion");

    property p_ready_high;
        @(posedge clk_in) disable iff (reset_in)
        $fell(result_ready_n_n_ff) && $past(since_fall_ff) != 8'hFF
        |-> $past(hi_cnt_ff) >= 8'd15;
    endproperty
    a_ready_high: assert property (p_ready_high)
        else $error("ready high time shorter than 16 clocks");

    property p_pin_driven;
        @(posedge clk_in) disable iff (reset_in)
        (clk_en_in && cs_fall && comm_ok) |=> shared_serial_out_ready_n_oe_out;
    endproperty
    a_pin_driven: assert property (p_pin_driven)
        else $error("shared pin not driven after chip select fell");

    property p_back_to_ready;
        @(posedge clk_in) disable iff (reset_in)
        (clk_en_in && sclk_fall && spi_active && !spi_timeout
         && bit_cnt_ff == 5'(DATA_W - 1))
        |=> shared_serial_out_ready_n_out == result_ready_n_n_ff;
    endproperty
    a_back_to_ready: assert property (p_back_to_ready)
        else $error("shared pin did not return to ready");

    property p_out_on_rise;
        @(posedge clk_in) disable iff (reset_in)
        $changed(out_bit_ff) |-> $past(sclk_rise);
    endproperty
    a_out_on_rise: assert property (p_out_on_rise)
        else $error("serial output changed off a rising edge");

    property p_in_on_fall;
        @(posedge clk_in) disable iff (reset_in)
        $changed(cmd_sr_ff) |-> $past(sclk_fall);
    endproperty
    a_in_on_fall: assert property (p_in_on_fall)
        else $error("serial input taken off a falling edge");

    property p_settle;
        @(posedge clk_in) disable iff (reset_in)
        ($past(state_ff) == ST_SETTLE && state_ff == ST_IDLE)
        |-> $past(settle_cnt_ff) == 10'(RESET_TO_CONV_CYC - 1);
    endproperty
    a_settle: assert property (p_settle)
        else $error("conversion allowed before reset wait ended");

    property p_blank;
        @(posedge clk_in) disable iff (reset_in)
        (clk_en_in && conv_start && ac_enable_in)
        |=> (ac_excitation_drive_out == 2'h0) [*8];
    endproperty
    a_blank: assert property (p_blank)
        else $error("excitation blanking shorter than 8 clocks");

    property p_start_ready;
        @(posedge clk_in) disable iff (reset_in)
        (clk_en_in && start_req) |=> result_ready_n_n_ff;
    endproperty
    a_start_ready: assert property (p_start_ready)
        else $error("ready not high after start request");
endmodule

// >>> tb.sv
// Purpose: self-checking bench for the converter timing control
// Assumes: shortened counts for power-on wait, idle timeout, period
// Notes:   expected values come from the counts set here
`timescale 1ns/1ns
module tb;
    import acct_pkg::*;
    localparam int unsigned POR = 64;
    localparam int unsigned IDLE = 40;
    localparam int unsigned CONV = 200;
    logic clk_in, reset_in, rst_pin_n, start, pd_n, valid, ac_en, fast;
    logic en;
    logic [23:0] sdata;
    logic [31:0] rx;
    logic drove, s_rdy, osc, rdy_n, sdo, oe, comm, conv;
    logic cs_n, sclk, din;
    logic [1:0] ac, lastp;
    int mismatches, checks, cyc, hi, z;
    acct_top #(.IDLE_CYC(IDLE), .POR_CYC(POR), .CONV_CYC(CONV)) acct_top_i (
        .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(en),
        .reset_pin_n_in(rst_pin_n), .start_in(start),
        .power_down_n_in(pd_n), .cs_n_in(cs_n), .sclk_in(sclk),
        .din_in(din), .sample_data_in(sdata), .sample_valid_in(valid),
        .sample_ready_out(s_rdy), .ac_enable_in(ac_en),
        .rate_fast_in(fast), .osc_fast_out(osc),
        .result_ready_n_out(rdy_n), .shared_serial_out_ready_n_out(sdo),
        .shared_serial_out_ready_n_oe_out(oe),
        .ac_excitation_drive_out(ac), .comm_ready_out(comm),
        .converting_out(conv));
    acct_host acct_host_i (.clk_in(clk_in), .sdo_in(sdo), .oe_in(oe),
        .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // bounded wait: 0 ready, 1 converting, 2 port open
    task automatic wt(input int sel, input logic v, input int mx);
        for (int i = 0; i < mx; i++) begin
            if ((sel == 0 ? rdy_n : sel == 1 ? conv : comm) === v) break;
            @(posedge clk_in);
        end
    endtask
    task automatic push(input logic [23:0] d);
        @(posedge clk_in) sdata <= d;
        valid <= 1'b1;
        @(posedge clk_in) valid <= 1'b0;
    endtask
    // ready high runs and excitation blanking watched all the time
    // sampled mid-cycle so outputs launched at the edge have settled
    always @(negedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            test_done();
        end
        if (rdy_n === 1'b1) hi++;
        else if (hi != 0) begin
            chk(hi >= 16, 1);
            hi = 0;
        end
        if (ac === 2'b00) z++;
        else begin
            if (z != 0 && z < 20 && lastp != 2'b00) begin
                chk(z, 8);
                chk({30'h0, ac}, {30'h0, ~lastp});
            end
            if (z != 0) lastp = ac;
            z = 0;
        end
    end
    initial begin
        {reset_in, rst_pin_n, start, pd_n, ac_en} = 5'h1F;
        en = 1'b1;
        {valid, fast, sdata, mismatches, checks, cyc, hi, z} = '0;
        lastp = 2'b00;
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (POR - 8) @(posedge clk_in);
        chk(comm, 0);
        wt(2, 1, 20);
        chk(comm, 1);
        push(24'h5A3C96);
        repeat (500) @(posedge clk_in);
        chk(conv, 0);
        wt(1, 1, 40);
        chk(conv, 1);
        wt(0, 0, CONV + 20);
        acct_host_i.xfer(32'h0, 24, rx, drove);
        chk(rx[23:0], 24'h5A3C96);
        chk(drove, 1);
        repeat (4) @(posedge clk_in);
        chk(acct_host_i.pin_level, rdy_n);
        acct_host_i.close();
        repeat (6) @(posedge clk_in);
        chk(oe, 0);
        push(24'h000011);
        wt(0, 1, CONV);
        wt(0, 0, CONV + 20);
        pd_n <= 1'b0;
        start <= 1'b0;
        repeat (12) @(posedge clk_in);
        chk(conv, 0);
        pd_n <= 1'b1;
        start <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk(rdy_n, 1);
        push(24'h000022);
        wt(0, 0, CONV + 20);
        repeat (160) @(posedge clk_in);
        start <= 1'b0;
        repeat (20) @(posedge clk_in);
        chk(conv, 1);
        wt(1, 0, CONV + 20);
        chk(conv, 0);
        acct_host_i.xfer(32'hFFFFFFFF, 3, rx, drove);
        acct_host_i.close();
        acct_host_i.xfer({CMD_START, 24'h0}, 8, rx, drove);
        acct_host_i.close();
        repeat (6) @(posedge clk_in);
        chk(conv, 1);
        acct_host_i.xfer(32'hFFFFFFFF, 3, rx, drove);
        repeat (IDLE + 20) @(posedge clk_in);
        acct_host_i.xfer({CMD_STOP, 24'h0}, 8, rx, drove);
        acct_host_i.close();
        wt(1, 0, CONV + 20);
        chk(conv, 0);
        rst_pin_n <= 1'b0;
        repeat (8) @(posedge clk_in);
        rst_pin_n <= 1'b1;
        start <= 1'b1;
        repeat (500) @(posedge clk_in);
        chk(conv, 0);
        wt(1, 1, 40);
        chk(conv, 1);
        start <= 1'b0;
        wt(1, 0, CONV + 20);
        for (int i = 0; i < 9; i++) push(24'(i));
        chk(s_rdy, 0);
        start <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wt(0, 1, CONV);
            wt(0, 0, CONV + 40);
        end
        start <= 1'b0;
        chk(s_rdy, 1);
        wt(1, 0, CONV + 20);
        acct_host_i.xfer(32'h0, 24, rx, drove);
        acct_host_i.close();
        chk(rx[23:0], 24'h000007);
        fast <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk(osc, 1);
        // clock enable low freezes the pin samplers, start goes unseen
        en <= 1'b0;
        start <= 1'b1;
        repeat (30) @(posedge clk_in);
        chk(conv, 0);
        en <= 1'b1;
        test_done();
    end
endmodule
